// File: design/scs_supervisor.v
// Contract
// - open command starts travel timer; position reads moving meanwhile
// - open contact before expiry: open and check ok, moving cleared together
// - travel expiry without open contact, settle zero: operation failed, fault, moving cleared
// - with settle configured, settle runs after travel, moving, then open
// - code 0 moving, 1 open, 2 closed; contact high 1, low 2
// - open contact not wired gives code 3, disturbed
// - three interlock conditions per direction each block that direction
// - protection trip and reclose skip interlocks; own block signals
// - assigned protection trip requests are ORed into one trip
// - only the combined trip drives the breaker; unassigned requests ignored
// - trip held at least minimum hold time; latching selectable
// - latched trip clears after requests drop, on ack or unlatch
// - external close and open inputs; open wins when both active
// - external close acts on rising edge, external open on level
// - permission none, local, remote, both; protection unaffected
// - SCADA close and open accepted only at remote or local-and-remote; ack and arm at any permission
// - bypass modes single command, permanent, timed; duration bounds single
// - bypass input signal also enables interlock bypass
// - manual position override replaces contact position and is flagged
// - one command at a time; new commands ignored while busy
// - command toward the current validated position is discarded
// - panel close key gives exactly one close pulse however long held
`timescale 1ns/100ps
`include "scs_regs.vh"
module scs_supervisor (
    // clock and reset
    input  wire                  core_clk,
    input  wire                  rst_n,
    // apb slave
    input  wire [7:0]            paddr,
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [31:0]           pwdata,
    output reg  [31:0]           prdata,
    output wire                  pready,
    output wire                  pslverr,
    // breaker auxiliary contact and pins
    input  wire                  open_contact,
    input  wire                  external_close_input,
    input  wire                  external_open_input,
    input  wire                  panel_close_key,
    input  wire                  panel_open_key,
    input  wire                  trip_ack_input,
    input  wire                  bypass_input,
    input  wire [2:0]            close_interlock,
    input  wire [2:0]            open_interlock,
    // protection and reclose logic, same clock
    input  wire [`SCS_SLOT_W-1:0] trip_request,
    input  wire                  trip_block,
    input  wire                  reclose_request,
    input  wire                  reclose_block,
    // breaker coils
    output reg                   close_coil,
    output reg                   open_coil,
    // position and status
    output reg  [1:0]            breaker_state_code,
    output reg                   position_open,
    output reg                   position_closed,
    output reg                   position_moving,
    output reg                   position_fault,
    output reg                   switch_check_ok,
    output reg                   override_active,
    output reg                   trip_active
);

localparam [2:0] ST_IDLE    = 3'h0;
localparam [2:0] ST_TRAVEL  = 3'h1;
localparam [2:0] ST_CLOSING = 3'h2;
localparam [2:0] ST_SETTLE  = 3'h3;
localparam [2:0] ST_FAULT   = 3'h4;

// configuration registers
reg  [`SCS_CTRL_W-1:0] ctrl_ff;
reg  [`SCS_SLOT_W-1:0] slot_ff;
reg  [`SCS_TMR_W-1:0]  travel_ff;
reg  [`SCS_TMR_W-1:0]  settle_ff;
reg  [`SCS_TMR_W-1:0]  hold_ff;
reg  [`SCS_TMR_W-1:0]  bypass_ff;

// state
reg  [2:0]             state_ff;
reg  [2:0]             nxt_state;
reg                    forced_open_ff;
reg                    nxt_forced_open;
reg                    check_ok_ff;
reg                    nxt_check_ok;
reg                    open_drive_ff;
reg                    nxt_open_drive;
reg                    single_used_ff;
reg  [4:0]             prev_ff;
reg  [1:0]             nxt_code;
wire                   bypass_active;
wire                   contact_s;
wire                   ext_close_s;
wire                   ext_open_s;
wire                   key_close_s;
wire                   key_open_s;
wire                   ack_in_s;
wire                   bypass_in_s;
wire [2:0]             ilock_close_s;
wire [2:0]             ilock_open_s;

wire [1:0]             perm;
wire [1:0]             byp_mode;
wire                   latch_en;
wire                   wired;
wire                   ovr_en;
wire [1:0]             ovr_pos;

wire                   wr_en;
wire                   rd_setup;
wire                   cmd_wr;
wire                   sw_close;
wire                   sw_open;
wire                   sw_ack;
wire                   sw_arm;

wire                   travel_busy;
wire                   travel_done;
wire                   hold_busy;
wire                   bypass_busy;
reg                    tmr_load;
reg  [`SCS_TMR_W-1:0]  tmr_preset;

scs_sync #(
    .WIDTH (13)
) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({open_interlock, close_interlock, bypass_input, trip_ack_input,
                panel_open_key, panel_close_key, external_open_input,
                external_close_input, open_contact}),
    .sync_out ({ilock_open_s, ilock_close_s, bypass_in_s, ack_in_s, key_open_s,
                key_close_s, ext_open_s, ext_close_s, contact_s})
);

assign perm     = ctrl_ff[`SCS_CTRL_PERM_LSB+1:`SCS_CTRL_PERM_LSB];
assign byp_mode = ctrl_ff[`SCS_CTRL_BYP_LSB+1:`SCS_CTRL_BYP_LSB];
assign latch_en = ctrl_ff[`SCS_CTRL_LATCH_BIT];
assign wired    = ctrl_ff[`SCS_CTRL_WIRED_BIT];
assign ovr_en   = ctrl_ff[`SCS_CTRL_OVR_BIT];
assign ovr_pos  = ctrl_ff[`SCS_CTRL_OVRPOS_LSB+1:`SCS_CTRL_OVRPOS_LSB];

// apb: zero wait states, read data captured in the setup cycle
assign pready   = 1'b1;
assign wr_en    = psel & penable & pwrite;
assign rd_setup = psel & ~penable & ~pwrite;
assign pslverr  = psel & penable & ((paddr[1:0] != 2'h0) || (paddr > `SCS_STATUS_OFS));
assign cmd_wr   = wr_en && (paddr == `SCS_CMD_OFS);
assign sw_close = cmd_wr & pwdata[`SCS_CMD_CLOSE_BIT];
assign sw_open  = cmd_wr & pwdata[`SCS_CMD_OPEN_BIT];
assign sw_ack   = cmd_wr & pwdata[`SCS_CMD_ACK_BIT];
assign sw_arm   = cmd_wr & pwdata[`SCS_CMD_ARM_BIT];

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        ctrl_ff   <= `SCS_CTRL_RST;
        slot_ff   <= `SCS_SLOT_RST;
        travel_ff <= `SCS_TRAVEL_RST;
        settle_ff <= `SCS_SETTLE_RST;
        hold_ff   <= `SCS_HOLD_RST;
        bypass_ff <= `SCS_BYPASS_RST;
    end else if (wr_en) begin
        if (paddr == `SCS_CTRL_OFS) begin
            ctrl_ff <= pwdata[`SCS_CTRL_W-1:0];
        end else if (paddr == `SCS_SLOT_OFS) begin
            slot_ff <= pwdata[`SCS_SLOT_W-1:0];
        end else if (paddr == `SCS_TRAVEL_OFS) begin
            travel_ff <= pwdata[`SCS_TMR_W-1:0];
        end else if (paddr == `SCS_SETTLE_OFS) begin
            settle_ff <= pwdata[`SCS_TMR_W-1:0];
        end else if (paddr == `SCS_HOLD_OFS) begin
            hold_ff <= pwdata[`SCS_TMR_W-1:0];
        end else if (paddr == `SCS_BYPASS_OFS) begin
            bypass_ff <= pwdata[`SCS_TMR_W-1:0];
        end
    end
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        prdata <= 32'h0;
    end else if (rd_setup) begin
        if (paddr == `SCS_CTRL_OFS) begin
            prdata <= {{(32-`SCS_CTRL_W){1'b0}}, ctrl_ff};
        end else if (paddr == `SCS_SLOT_OFS) begin
            prdata <= {{(32-`SCS_SLOT_W){1'b0}}, slot_ff};
        end else if (paddr == `SCS_TRAVEL_OFS) begin
            prdata <= {8'h0, travel_ff};
        end else if (paddr == `SCS_SETTLE_OFS) begin
            prdata <= {8'h0, settle_ff};
        end else if (paddr == `SCS_HOLD_OFS) begin
            prdata <= {8'h0, hold_ff};
        end else if (paddr == `SCS_BYPASS_OFS) begin
            prdata <= {8'h0, bypass_ff};
        end else if (paddr == `SCS_STATUS_OFS) begin
            prdata <= {20'h0, state_ff, bypass_active, trip_active, override_active,
                       switch_check_ok, position_fault, open_coil, close_coil,
                       breaker_state_code};
        end else begin
            prdata <= 32'h0;
        end
    end
end

// edge detection on synchronised and same-clock inputs
wire key_close_rise = key_close_s & ~prev_ff[0];
wire key_open_rise  = key_open_s & ~prev_ff[1];
wire ext_close_rise = ext_close_s & ~prev_ff[2];
wire ack_in_rise    = ack_in_s & ~prev_ff[3];
wire reclose_rise   = reclose_request & ~prev_ff[4];

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        prev_ff <= 5'h0;
    end else begin
        prev_ff <= {reclose_request, ack_in_s, ext_close_s, key_open_s, key_close_s};
    end
end

// protection trip combining and holding
wire trip_any   = |(trip_request & slot_ff) & ~trip_block;
wire trip_ack   = sw_ack | ack_in_rise;
wire trip_clear = ~trip_any & ~hold_busy &
                  (~latch_en | trip_ack | (slot_ff == `SCS_SLOT_RST));

scs_timer u_hold (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (trip_any & ~trip_active),
    .clear    (1'b0),
    .preset   (hold_ff),
    .busy     (hold_busy),
    .done     ()
);

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        trip_active <= 1'b0;
    end else if (trip_any) begin
        trip_active <= 1'b1;
    end else if (trip_clear) begin
        trip_active <= 1'b0;
    end
end

// interlock bypass
assign bypass_active = (byp_mode == `SCS_BYP_PERM) | bypass_in_s |
                     (bypass_busy & ~single_used_ff &
                      ((byp_mode == `SCS_BYP_SINGLE) || (byp_mode == `SCS_BYP_TIMED)));

scs_timer u_bypass (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (sw_arm),
    .clear    (byp_mode == `SCS_BYP_OFF),
    .preset   (bypass_ff),
    .busy     (bypass_busy),
    .done     ()
);

// command sources, permission and checks
wire perm_local  = (perm == `SCS_PERM_LOCAL) || (perm == `SCS_PERM_BOTH);
wire perm_remote = (perm == `SCS_PERM_REMOTE) || (perm == `SCS_PERM_BOTH);
wire man_open    = (perm_local & key_open_rise) |
                   (perm_remote & (sw_open | ext_open_s));
wire man_close   = (perm_local & key_close_rise) |
                   (perm_remote & (sw_close | ext_close_rise));
wire open_free   = ~(|ilock_open_s) | bypass_active;
wire close_free  = ~(|ilock_close_s) | bypass_active;
wire cmd_idle    = (state_ff == ST_IDLE) || (state_ff == ST_FAULT);
wire open_go     = cmd_idle & man_open & open_free &
                   (breaker_state_code != `SCS_POS_OPEN);
wire close_go    = cmd_idle & ~man_open &
                   ((man_close & close_free) | (reclose_rise & ~reclose_block)) &
                   (breaker_state_code != `SCS_POS_CLOSED);
wire trip_go     = cmd_idle & trip_any & ~trip_active &
                   (breaker_state_code != `SCS_POS_OPEN);

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        single_used_ff <= 1'b0;
    end else if ((byp_mode == `SCS_BYP_SINGLE) && bypass_busy && (open_go | close_go)) begin
        single_used_ff <= 1'b1;
    end else if (sw_arm) begin
        single_used_ff <= 1'b0;
    end
end

// travel, closing and settle share one timer since they never overlap
scs_timer u_travel (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .clear    (1'b0),
    .preset   (tmr_preset),
    .busy     (travel_busy),
    .done     (travel_done)
);

always @* begin
    nxt_state       = state_ff;
    nxt_forced_open = forced_open_ff;
    nxt_check_ok    = check_ok_ff;
    nxt_open_drive  = open_drive_ff;
    tmr_load        = 1'b0;
    tmr_preset      = travel_ff;
    case (state_ff)
        ST_IDLE, ST_FAULT: begin
            if (open_go | trip_go) begin
                nxt_state       = ST_TRAVEL;
                tmr_load        = 1'b1;
                nxt_forced_open = 1'b0;
                nxt_check_ok    = 1'b0;
                nxt_open_drive  = open_go;
            end else if (close_go) begin
                nxt_state       = ST_CLOSING;
                tmr_load        = 1'b1;
                nxt_forced_open = 1'b0;
                nxt_check_ok    = 1'b0;
            end else if ((state_ff == ST_FAULT) && contact_s) begin
                nxt_state = ST_IDLE;
            end
        end
        ST_TRAVEL: begin
            if (contact_s) begin
                nxt_state      = ST_IDLE;
                nxt_check_ok   = 1'b1;
                nxt_open_drive = 1'b0;
            end else if (travel_done || !travel_busy) begin
                nxt_open_drive = 1'b0;
                if (settle_ff != {`SCS_TMR_W{1'b0}}) begin
                    nxt_state  = ST_SETTLE;
                    tmr_load   = 1'b1;
                    tmr_preset = settle_ff;
                    nxt_forced_open = 1'b1;
                end else begin
                    nxt_state = ST_FAULT;
                end
            end
        end
        ST_CLOSING: begin
            if (travel_done || !travel_busy) begin
                if (settle_ff != {`SCS_TMR_W{1'b0}}) begin
                    nxt_state  = ST_SETTLE;
                    tmr_load   = 1'b1;
                    tmr_preset = settle_ff;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
        end
        ST_SETTLE: begin
            if (travel_done || !travel_busy) begin
                nxt_state = ST_IDLE;
            end
        end
        default: begin
            nxt_state = ST_IDLE;
        end
    endcase
end

// validated position code
always @* begin
    if (ovr_en) begin
        nxt_code = ovr_pos;
    end else if (!wired) begin
        nxt_code = `SCS_POS_DISTURB;
    end else if ((nxt_state == ST_TRAVEL) || (nxt_state == ST_CLOSING) ||
                 (nxt_state == ST_SETTLE)) begin
        nxt_code = `SCS_POS_MOVING;
    end else if (nxt_state == ST_FAULT) begin
        nxt_code = `SCS_POS_DISTURB;
    end else if (contact_s || nxt_forced_open) begin
        nxt_code = `SCS_POS_OPEN;
    end else begin
        nxt_code = `SCS_POS_CLOSED;
    end
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_ff           <= ST_IDLE;
        forced_open_ff     <= 1'b0;
        check_ok_ff        <= 1'b0;
        open_drive_ff      <= 1'b0;
        breaker_state_code <= `SCS_POS_DISTURB;
        position_open      <= 1'b0;
        position_closed    <= 1'b0;
        position_moving    <= 1'b0;
        position_fault     <= 1'b0;
        switch_check_ok    <= 1'b0;
        override_active    <= 1'b0;
        close_coil         <= 1'b0;
        open_coil          <= 1'b0;
    end else begin
        state_ff           <= nxt_state;
        forced_open_ff     <= nxt_forced_open;
        check_ok_ff        <= nxt_check_ok;
        open_drive_ff      <= nxt_open_drive;
        breaker_state_code <= nxt_code;
        position_open      <= (nxt_code == `SCS_POS_OPEN);
        position_closed    <= (nxt_code == `SCS_POS_CLOSED);
        position_moving    <= (nxt_code == `SCS_POS_MOVING);
        position_fault     <= (nxt_state == ST_FAULT);
        switch_check_ok    <= nxt_check_ok;
        override_active    <= ovr_en;
        close_coil         <= (nxt_state == ST_CLOSING);
        open_coil          <= trip_any | trip_active | nxt_open_drive;
    end
end

endmodule

// File: design/scs_sync.v
`timescale 1ns/100ps
module scs_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             rst_n,
    // asynchronous inputs and filtered result
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_ff;
reg [WIDTH-1:0] stage2_ff;
reg [WIDTH-1:0] stage3_ff;
integer         i;

// a change is taken once the second and third stages agree
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        meta_ff   <= {WIDTH{1'b0}};
        stage2_ff <= {WIDTH{1'b0}};
        stage3_ff <= {WIDTH{1'b0}};
        sync_out  <= {WIDTH{1'b0}};
    end else begin
        meta_ff   <= async_in;
        stage2_ff <= meta_ff;
        stage3_ff <= stage2_ff;
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2_ff[i] == stage3_ff[i]) begin
                sync_out[i] <= stage3_ff[i];
            end
        end
    end
end

endmodule

// File: design/scs_timer.v
`timescale 1ns/100ps
`include "scs_regs.vh"
module scs_timer (
    // clock and reset
    input  wire                  core_clk,
    input  wire                  rst_n,
    // control
    input  wire                  load,
    input  wire                  clear,
    input  wire [`SCS_TMR_W-1:0] preset,
    // status
    output wire                  busy,
    output wire                  done
);

reg [`SCS_TMR_W-1:0] count_ff;

assign busy = (count_ff != {`SCS_TMR_W{1'b0}});
assign done = (count_ff == {{(`SCS_TMR_W-1){1'b0}}, 1'b1});

// counts down in core clock ticks; load wins over clear
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        count_ff <= {`SCS_TMR_W{1'b0}};
    end else if (load) begin
        count_ff <= preset;
    end else if (clear) begin
        count_ff <= {`SCS_TMR_W{1'b0}};
    end else if (busy) begin
        count_ff <= count_ff - {{(`SCS_TMR_W-1){1'b0}}, 1'b1};
    end
end

endmodule

// File: shared/scs_regs.vh
`ifndef SCS_REGS_VH
`define SCS_REGS_VH

// register byte offsets
`define SCS_CTRL_OFS        8'h00
`define SCS_SLOT_OFS        8'h04
`define SCS_TRAVEL_OFS      8'h08
`define SCS_SETTLE_OFS      8'h0c
`define SCS_HOLD_OFS        8'h10
`define SCS_BYPASS_OFS      8'h14
`define SCS_CMD_OFS         8'h18
`define SCS_STATUS_OFS      8'h1c

// control register fields
`define SCS_CTRL_PERM_LSB   0
`define SCS_CTRL_BYP_LSB    2
`define SCS_CTRL_LATCH_BIT  4
`define SCS_CTRL_WIRED_BIT  5
`define SCS_CTRL_OVR_BIT    6
`define SCS_CTRL_OVRPOS_LSB 7
`define SCS_CTRL_W          9

// command register bits, write-one pulses
`define SCS_CMD_CLOSE_BIT   0
`define SCS_CMD_OPEN_BIT    1
`define SCS_CMD_ACK_BIT     2
`define SCS_CMD_ARM_BIT     3

// permission levels
`define SCS_PERM_NONE       2'h0
`define SCS_PERM_LOCAL      2'h1
`define SCS_PERM_REMOTE     2'h2
`define SCS_PERM_BOTH       2'h3

// bypass modes
`define SCS_BYP_OFF         2'h0
`define SCS_BYP_SINGLE      2'h1
`define SCS_BYP_PERM        2'h2
`define SCS_BYP_TIMED       2'h3

// position codes
`define SCS_POS_MOVING      2'h0
`define SCS_POS_OPEN        2'h1
`define SCS_POS_CLOSED      2'h2
`define SCS_POS_DISTURB     2'h3

// widths and reset values
`define SCS_TMR_W           24
`define SCS_SLOT_W          8
`define SCS_CTRL_RST        9'h020
`define SCS_SLOT_RST        8'h00

// timing: default presets in clock ticks, 100 us at 40 MHz; settle defaults to 0
`define SCS_TRAVEL_RST      24'h000fa0
`define SCS_SETTLE_RST      24'h000000
`define SCS_HOLD_RST        24'h000fa0
`define SCS_BYPASS_RST      24'h000fa0

`endif

// File: test/scs_breaker.sv
`timescale 1ns/100ps
module scs_breaker (
    // clock and coil drives
    input  wire  core_clk,
    input  wire  open_coil,
    input  wire  close_coil,
    // jammed mechanism ignores the open coil
    input  wire  stuck,
    // open-side contact, high when open
    output logic open_contact
);
    logic [2:0] cnt_ff = 3'h0;
    initial open_contact = 1'b1;
    // contact moves after five cycles of coil drive
    always @(posedge core_clk) begin
        if ((open_coil && !stuck) || close_coil) begin
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == 3'h4) open_contact <= open_coil && !stuck;
        end else cnt_ff <= 3'h0;
    end
endmodule

// File: test/scs_props.sv
`timescale 1ns/100ps
module scs_props (
    // clock, reset and trip inputs
    input wire       core_clk,
    input wire       rst_n,
    input wire [7:0] trip_request,
    input wire       trip_block,
    // coils and status
    input wire       close_coil,
    input wire       open_coil,
    input wire [1:0] breaker_state_code,
    input wire       position_open,
    input wire       position_moving,
    input wire       position_fault,
    input wire       switch_check_ok,
    input wire       trip_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_state_decode: assert property (position_moving == (breaker_state_code == 2'h0)
        && position_open == (breaker_state_code == 2'h1)) else $error("state decode");
    a_check_ok_open: assert property ($rose(switch_check_ok) |-> position_open
        && !position_moving && $past(position_moving)) else $error("check ok without open");
    a_fault_code: assert property ($rose(position_fault) |->
        breaker_state_code == 2'h3 && !position_moving) else $error("fault code");
    a_trip_coil: assert property (trip_active |-> open_coil) else $error("trip coil");
    a_trip_cause: assert property ($rose(trip_active) |-> $past(trip_request) != 8'h00
        && !$past(trip_block)) else $error("trip without request");
    a_trip_hold: assert property ($rose(trip_active) |-> trip_active[*4])
        else $error("trip too short");
    a_close_dir: assert property ($rose(close_coil) |-> position_moving
        && $past(breaker_state_code) != 2'h2) else $error("close toward closed");
    a_open_moving: assert property ($rose(open_coil) && !trip_active |->
        position_moving && $past(breaker_state_code) != 2'h1) else $error("open start");
endmodule
bind scs_supervisor scs_props u_props (.core_clk, .rst_n, .trip_request, .trip_block,
    .close_coil, .open_coil, .breaker_state_code, .position_open, .position_moving,
    .position_fault, .switch_check_ok, .trip_active);

// File: test/scs_supervisor_tb.sv
`timescale 1ns/100ps
`include "scs_regs.vh"
module scs_supervisor_tb;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, stuck = 0;
    logic [7:0] paddr = 0, trip_request = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic external_close_input = 0, external_open_input = 0, panel_close_key = 0;
    logic trip_ack_input = 0, bypass_input = 0, pready, open_contact, close_coil, open_coil;
    logic [2:0] close_interlock = 0;
    logic position_fault, switch_check_ok, trip_active, override_active;
    logic [1:0] breaker_state_code;
    int n_mismatch = 0, n_compared = 0, n_cl = 0;
    always #12.5 core_clk = ~core_clk;
    always @(posedge close_coil) n_cl++;
    scs_supervisor u_dut (.core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr(), .open_contact, .external_close_input,
        .external_open_input, .panel_close_key, .panel_open_key(1'b0), .trip_ack_input,
        .bypass_input, .close_interlock, .open_interlock(3'h0), .trip_request,
        .trip_block(1'b0), .reclose_request(1'b0), .reclose_block(1'b0), .close_coil,
        .open_coil, .breaker_state_code, .position_open(), .position_closed(),
        .position_moving(), .position_fault, .switch_check_ok, .override_active,
        .trip_active);
    scs_breaker u_brk (.core_clk, .open_coil, .close_coil, .stuck, .open_contact);
    task xfer(input w, input [7:0] a, input [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task wcode(input [1:0] c);
        for (int i = 0; i < 300 && breaker_state_code !== c; i++) @(posedge core_clk);
    endtask
    task end_sim;
        if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        xfer(0, `SCS_CTRL_OFS, 0);
        chk("ctrl reset", 32'h20, q);
        xfer(0, 8'h20, 0);
        xfer(1, `SCS_CTRL_OFS, 32'h23);
        xfer(1, `SCS_SLOT_OFS, 32'h1);
        xfer(1, `SCS_TRAVEL_OFS, 32'h10);
        xfer(1, `SCS_HOLD_OFS, 32'h8);
        wcode(2'h1);
        chk("code open", 1, breaker_state_code);
        xfer(1, `SCS_CMD_OFS, 32'h2);
        repeat (20) @(posedge core_clk);
        chk("open twice", 0, switch_check_ok);
        close_interlock <= 3'h1;
        external_close_input <= 1'b1;
        repeat (30) @(posedge core_clk);
        chk("locked close", 0, n_cl);
        external_close_input <= 1'b0;
        bypass_input <= 1'b1;
        repeat (8) @(posedge core_clk);
        external_close_input <= 1'b1;
        wcode(2'h2);
        chk("bypass close", 2, breaker_state_code);
        external_close_input <= 1'b0;
        bypass_input <= 1'b0;
        close_interlock <= 3'h0;
        repeat (8) @(posedge core_clk);
        external_close_input <= 1'b1;
        external_open_input <= 1'b1;
        wcode(2'h1);
        chk("open ok", 1, switch_check_ok);
        chk("open wins", 1, n_cl);
        external_close_input <= 1'b0;
        external_open_input <= 1'b0;
        panel_close_key <= 1'b1;
        wcode(2'h2);
        xfer(1, `SCS_CMD_OFS, 32'h2);
        wcode(2'h1);
        repeat (60) @(posedge core_clk);
        chk("one pulse", 2, n_cl);
        panel_close_key <= 1'b0;
        repeat (8) @(posedge core_clk);
        panel_close_key <= 1'b1;
        wcode(2'h2);
        panel_close_key <= 1'b0;
        stuck <= 1'b1;
        xfer(1, `SCS_CMD_OFS, 32'h2);
        wcode(2'h3);
        chk("fault", 1, position_fault);
        stuck <= 1'b0;
        trip_request <= 8'h2;
        repeat (10) @(posedge core_clk);
        chk("unassigned", 0, trip_active);
        xfer(1, `SCS_CTRL_OFS, 32'h33);
        trip_request <= 8'h1;
        repeat (3) @(posedge core_clk);
        chk("trip", 1, trip_active);
        trip_request <= 8'h0;
        repeat (30) @(posedge core_clk);
        chk("latched", 1, trip_active);
        trip_ack_input <= 1'b1;
        repeat (6) @(posedge core_clk);
        trip_ack_input <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk("acked", 0, trip_active);
        xfer(1, `SCS_CTRL_OFS, 32'h20);
        xfer(1, `SCS_CMD_OFS, 32'h1);
        repeat (30) @(posedge core_clk);
        chk("no permission", 3, n_cl);
        xfer(1, `SCS_CTRL_OFS, 32'h160);
        repeat (2) @(posedge core_clk);
        chk("override code", 2, breaker_state_code);
        chk("override flag", 1, override_active);
        end_sim();
    end
endmodule
